// [dv/uart_it_harness_properties.sv]
// Checker for the harness outputs and clear mux, beside the link.
// Assumes one hclk domain and the harness mode and mux signals.
`timescale 1ns/1ps

module uart_it_harness_properties
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        integration_mode_enable,
  input wire logic [15:0] func_out,
  input wire logic        int_tx_dma_clear,
  input wire logic        int_rx_dma_clear,
  input wire logic        tx_dma_clear,
  input wire logic        rx_dma_clear,
  input wire logic        tx_single_dma_request,
  input wire logic        tx_burst_dma_request,
  input wire logic        rx_single_dma_request,
  input wire logic        rx_burst_dma_request,
  input wire logic        modem_status_irq,
  input wire logic        receive_irq,
  input wire logic        transmit_irq,
  input wire logic        receive_timeout_irq,
  input wire logic        error_irq,
  input wire logic        combined_irq,
  input wire logic        user_output_two_n,
  input wire logic        user_output_one_n,
  input wire logic        request_to_send_n,
  input wire logic        terminal_ready_n,
  input wire logic        infrared_out_n,
  input wire logic        serial_tx_data
);
  wire [15:0] outs = {tx_single_dma_request, tx_burst_dma_request,
    rx_single_dma_request, rx_burst_dma_request, modem_status_irq,
    receive_irq, transmit_irq, receive_timeout_irq, error_irq,
    combined_irq, user_output_two_n, user_output_one_n,
    request_to_send_n, terminal_ready_n, infrared_out_n, serial_tx_data};
  wire        mode = integration_mode_enable;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_NORMAL_INTRA: assert property
    (!mode |-> outs[15:6] == func_out[15:6])
    else $error("intra outputs differ from normal logic");
  AST_NORMAL_PRIM: assert property
    (!mode |-> outs[5:0] == func_out[5:0])
    else $error("pad outputs differ from normal logic");
  AST_CLR_PASS_TX: assert property
    (!mode |-> int_tx_dma_clear == tx_dma_clear)
    else $error("tx clear not passed through");
  AST_CLR_PASS_RX: assert property
    (!mode |-> int_rx_dma_clear == rx_dma_clear)
    else $error("rx clear not passed through");
  // Normal logic must not leak through while the override owns the pins
  AST_HOLD_INTRA: assert property
    (mode && $past(mode) && $changed(func_out) |-> $stable(outs[15:6]))
    else $error("intra outputs follow normal logic in test mode");
  AST_HOLD_PRIM: assert property
    (mode && $past(mode) && $changed(func_out) |-> $stable(outs[5:0]))
    else $error("pad outputs follow normal logic in test mode");
  AST_CLR_HOLD_TX: assert property
    (mode && $past(mode) && $changed(tx_dma_clear)
      |-> $stable(int_tx_dma_clear))
    else $error("tx clear leaks through in test mode");
  AST_CLR_HOLD_RX: assert property
    (mode && $past(mode) && $changed(rx_dma_clear)
      |-> $stable(int_rx_dma_clear))
    else $error("rx clear leaks through in test mode");

  cover property ($rose(mode));
  cover property (mode && $changed(tx_dma_clear));
  cover property (!mode && $changed(rx_dma_clear));
endmodule

// [dv/uart_it_harness_tb.sv]
// Bench for the harness joined to its partner over the link.
// Assumes the register offsets and the partner loopback of the note.
`timescale 1ns/1ps

module uart_it_harness_tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic [15:0] func_out = 16'hA5C3;
  logic [10:0] tx_rdata = 11'h5A5;
  logic        loop_en = 1'b0;
  logic        tx_clr = 1'b0;
  logic        rx_clr = 1'b0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        itx;
  logic        irx;
  logic        mode;
  logic        sir;
  logic        fifo_en;
  logic [5:0]  pins_obs;
  logic        push;
  logic        pop;
  logic [10:0] wd;
  logic [10:0] last_wd;
  logic [9:0]  intra_obs;
  int          err_count = 0;
  int          n_tests = 0;
  int          pushes = 0;
  int          pops = 0;
  int          cyc = 0;
  int          i;

  uart_it_link lk();
  wire [15:0] outs = {lk.tx_single_dma_request, lk.tx_burst_dma_request,
    lk.rx_single_dma_request, lk.rx_burst_dma_request, lk.modem_status_irq,
    lk.receive_irq, lk.transmit_irq, lk.receive_timeout_irq, lk.error_irq,
    lk.combined_irq, lk.user_output_two_n, lk.user_output_one_n,
    lk.request_to_send_n, lk.terminal_ready_n, lk.infrared_out_n,
    lk.serial_tx_data};

  uart_it_harness uart_it_harness_i
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .link(lk.harness), .func_out(func_out),
    .int_tx_dma_clear(itx), .int_rx_dma_clear(irx),
    .integration_mode_enable(mode), .fifo_direct_access_enable(fifo_en),
    .sir_full_duplex_test(sir), .rx_fifo_push(push), .rx_fifo_wdata(wd),
    .tx_fifo_pop(pop), .tx_fifo_rdata(tx_rdata)
  );

  uart_it_partner uart_it_partner_i
  (
    .hclk(hclk), .hresetn(hresetn), .link(lk.partner),
    .loopback_enable(loop_en), .tx_clear_drive(tx_clr),
    .rx_clear_drive(rx_clr), .intra_observed_q(intra_obs),
    .pins_observed_q(pins_obs)
  );

  uart_it_harness_properties uart_it_harness_properties_i
  (
    .hclk(hclk), .hresetn(hresetn), .integration_mode_enable(mode),
    .func_out(func_out), .int_tx_dma_clear(itx), .int_rx_dma_clear(irx),
    .tx_dma_clear(lk.tx_dma_clear), .rx_dma_clear(lk.rx_dma_clear),
    .tx_single_dma_request(lk.tx_single_dma_request),
    .tx_burst_dma_request(lk.tx_burst_dma_request),
    .rx_single_dma_request(lk.rx_single_dma_request),
    .rx_burst_dma_request(lk.rx_burst_dma_request),
    .modem_status_irq(lk.modem_status_irq), .receive_irq(lk.receive_irq),
    .transmit_irq(lk.transmit_irq), .error_irq(lk.error_irq),
    .receive_timeout_irq(lk.receive_timeout_irq),
    .combined_irq(lk.combined_irq),
    .user_output_two_n(lk.user_output_two_n),
    .user_output_one_n(lk.user_output_one_n),
    .request_to_send_n(lk.request_to_send_n),
    .terminal_ready_n(lk.terminal_ready_n),
    .infrared_out_n(lk.infrared_out_n), .serial_tx_data(lk.serial_tx_data)
  );

  always #5 hclk = ~hclk;

  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  // FIFO strobes are one-cycle pulses, so count them at every edge
  always @(posedge hclk)
  begin
    if (push === 1'b1)
    begin
      pushes++;
      last_wd = wd;
    end
    if (pop === 1'b1)
      pops++;
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    begin
      n_tests++;
      if (g !== e)
      begin
        err_count++;
        $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
    end
  endtask

  // One AHB-Lite single transfer; called just after a rising edge
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    begin
      hsel <= 1'b1;
      haddr <= {20'h0_0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    begin
      bus(1'b1, a, d, r);
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input string m);
    logic [31:0] r;
    begin
      bus(1'b0, a, 32'h0000_0000, r);
      chk(r, e, m);
    end
  endtask

  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(12'h080, 32'h0000_0000, "control reset");
    rd(12'h088, {16'h0000, func_out[15:6], 6'h00}, "override normal");
    chk(32'(outs), 32'(func_out), "normal outputs");
    $display("test reset done");
    wr(12'h080, 32'h0000_0001);
    for (i = 0; i < 16; i++)
    begin
      wr(12'h088, 32'h0000_0001 << i);
      rd(12'h088, 32'h0000_0001 << i, "override readback");
      chk(32'(outs), 32'h0000_0001 << i, "override drive");
      chk(32'(intra_obs), (32'h0000_0001 << i) >> 6, "controller");
    end
    chk(32'(intra_obs), 32'h0000_0200, "controller view");
    func_out <= 16'h5A3C;
    repeat (2) @(posedge hclk);
    chk(32'(outs), 32'h0000_8000, "outputs held");
    $display("test override done");
    loop_en <= 1'b1;
    for (i = 0; i < 2; i++)
    begin
      wr(12'h088, i ? 32'h0000_0015 : 32'h0000_002A);
      repeat (3) @(posedge hclk);
      rd(12'h084, i ? 32'h0000_0015 : 32'h0000_002A, "loopback");
      chk(32'(pins_obs), i ? 32'h0000_0019 : 32'h0000_0026,
          "fixture view");
    end
    loop_en <= 1'b0;
    repeat (3) @(posedge hclk);
    rd(12'h084, 32'h0000_003F, "idle pins");
    $display("test loopback done");
    for (i = 3; i >= 0; i--)
    begin
      wr(12'h084, 32'(i) << 6);
      rd(12'h084, (32'(i) << 6) | 32'h3F, "input bits");
      chk({30'h0, itx, irx}, 32'(i), "stored clears");
    end
    tx_clr <= 1'b1;
    rx_clr <= 1'b1;
    repeat (3) @(posedge hclk);
    rd(12'h084, 32'h0000_003F, "clears masked");
    wr(12'h080, 32'h0000_0000);
    // The mode bit lands at the edge that ends the data phase
    @(posedge hclk);
    chk({30'h0, itx, irx}, 32'h0000_0003, "clears passed");
    rd(12'h084, 32'h0000_00FF, "clears seen");
    tx_clr <= 1'b0;
    repeat (2) @(posedge hclk);
    rd(12'h084, 32'h0000_007F, "tx clear low");
    rx_clr <= 1'b0;
    repeat (2) @(posedge hclk);
    rd(12'h084, 32'h0000_003F, "rx clear low");
    chk(32'(outs), 32'h0000_5A3C, "normal again");
    $display("test clears done");
    wr(12'h08C, 32'h0001_FABC);
    rd(12'h08C, 32'h0000_0000, "fifo off read");
    chk(pushes + pops, 0, "no fifo access");
    wr(12'h080, 32'h0000_0002);
    wr(12'h08C, 32'h0001_FABC);
    rd(12'h08C, 32'h0000_05A5, "fifo pop data");
    chk(32'(last_wd), 32'h0000_02BC, "fifo push data");
    chk(pushes * 16 + pops, 17, "one push one pop");
    rd(12'h090, 32'h0000_0000, "unmapped");
    chk(32'(hresp), 32'h0000_0000, "okay response");
    wr(12'h080, 32'h0000_0007);
    rd(12'h080, 32'h0000_0007, "control bits");
    chk({29'h0, sir, fifo_en, mode}, 32'h0000_0007, "ctrl outs");
    $display("test fifo done");
    conclude();
  end
endmodule

// [verilog/uart_it_defines.svh]
// Constants of the serial-port integration-test harness and its partner.
// Assumes inclusion by bare name from every file that needs them.
`ifndef UART_IT_DEFINES_SVH
`define UART_IT_DEFINES_SVH

// Register byte offsets (haddr[11:0])
`define TEST_CTRL_OFS      12'h080
`define INPUT_REG_OFS      12'h084
`define OUTPUT_OVR_OFS     12'h088
`define TEST_DATA_OFS      12'h08C
`define OFS_W              12

// Register widths and reset values
`define TEST_CTRL_W        3
`define TEST_CTRL_RST      3'h0
`define INPUT_HOLD_W       2
`define INPUT_HOLD_RST     2'h0
`define OUTPUT_OVR_W       16
`define OUTPUT_OVR_RST     16'h0000
`define TEST_DATA_W        11
`define PIN_IN_W           6
`define INTRA_W            10

// Test control fields
`define TCR_INTEGRATION_MODE_ENABLE_BIT       0
`define TCR_FIFO_BIT       1
`define TCR_SIR_BIT        2

// Input register fields
`define ITIP_TXCLR_BIT     7
`define ITIP_RXCLR_BIT     6
`define ITIP_PIN_MSB       5

// Output override fields
`define OVR_TXSREQ         15
`define OVR_TXBREQ         14
`define OVR_RXSREQ         13
`define OVR_RXBREQ         12
`define OVR_MSIRQ          11
`define OVR_RXIRQ          10
`define OVR_TXIRQ          9
`define OVR_RTIRQ          8
`define OVR_ERRIRQ         7
`define OVR_ALLIRQ         6
`define OVR_OUT2           5
`define OVR_OUT1           4
`define OVR_RTS            3
`define OVR_DTR            2
`define OVR_IROUT          1
`define OVR_TXD            0
`define OVR_INTRA_LSB      6
`define OVR_PRIM_MSB       5

// Idle level of a looped pin when the fixture is not joining it
`define PIN_IDLE           6'h3F

`endif

// [verilog/uart_it_harness.sv]
// Integration-test harness of the serial port, AHB-Lite register slave.
// Assumes normal logic, FIFOs and partner on the same hclk.
//
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "uart_it_defines.svh"

module uart_it_harness
(
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic [31:0]                  hrdata,
  uart_it_link.harness                 link,
  input  wire logic [`OUTPUT_OVR_W-1:0] func_out,
  output logic                         int_tx_dma_clear,
  output logic                         int_rx_dma_clear,
  output logic                         integration_mode_enable,
  output logic                         fifo_direct_access_enable,
  output logic                         sir_full_duplex_test,
  output logic                         rx_fifo_push,
  output logic [`TEST_DATA_W-1:0]      rx_fifo_wdata,
  output logic                         tx_fifo_pop,
  input  wire logic [`TEST_DATA_W-1:0] tx_fifo_rdata
);

  uart_it_pkg::bus_state_e   state_q;
  uart_it_pkg::bus_state_e   state_d;
  logic [`OFS_W-1:0]         addr_q;
  logic [`TEST_CTRL_W-1:0]   tcr_q;
  logic [`INPUT_HOLD_W-1:0]  input_hold_q;
  logic [`OUTPUT_OVR_W-1:0]  ovr_q;
  logic [`OUTPUT_OVR_W-1:0]  out_mux;
  logic [`PIN_IN_W-1:0]      pin_s1_q;
  logic [`PIN_IN_W-1:0]      pin_s2_q;
  logic [31:0]               rdata_d;
  logic                      accept;
  logic                      wr_phase;
  logic                      rd_phase;
  logic                      tdr_hit;

  assign integration_mode_enable   = tcr_q[`TCR_INTEGRATION_MODE_ENABLE_BIT];
  assign fifo_direct_access_enable = tcr_q[`TCR_FIFO_BIT];
  assign sir_full_duplex_test      = tcr_q[`TCR_SIR_BIT];

  // Bus: address phase taken when selected, ready and NONSEQ/SEQ
  assign accept   = hsel && hready && htrans[1];
  assign wr_phase = (state_q == uart_it_pkg::BUS_WRITE);
  assign rd_phase = (state_q == uart_it_pkg::BUS_RD_WAIT);
  assign tdr_hit  = (addr_q == `TEST_DATA_OFS);

  // Reads take one wait state so a read right after a write sees it
  assign hreadyout = (state_q != uart_it_pkg::BUS_RD_WAIT);
  assign hresp     = 1'b0;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      uart_it_pkg::BUS_RD_WAIT:
        state_d = uart_it_pkg::BUS_RD_DONE;
      default:
        if (accept)
          state_d = hwrite ? uart_it_pkg::BUS_WRITE
                           : uart_it_pkg::BUS_RD_WAIT;
        else
          state_d = uart_it_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= uart_it_pkg::BUS_IDLE;
      addr_q  <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (accept && hreadyout)
        addr_q <= haddr[`OFS_W-1:0];
    end
  end

  // Control, input-hold and override registers, written in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tcr_q        <= `TEST_CTRL_RST;
      input_hold_q <= `INPUT_HOLD_RST;
      ovr_q        <= `OUTPUT_OVR_RST;
    end
    else if (wr_phase)
    begin
      case (addr_q)
        `TEST_CTRL_OFS:
          tcr_q <= hwdata[`TEST_CTRL_W-1:0];
        `INPUT_REG_OFS:
          input_hold_q <= hwdata[`ITIP_TXCLR_BIT:`ITIP_RXCLR_BIT];
        `OUTPUT_OVR_OFS:
          ovr_q <= hwdata[`OUTPUT_OVR_W-1:0];
        default:
          tcr_q <= tcr_q;
      endcase
    end
  end

  // Direct FIFO access; refused silently while access is disabled
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_fifo_push  <= 1'b0;
      rx_fifo_wdata <= '0;
    end
    else
    begin
      rx_fifo_push <= wr_phase && tdr_hit && fifo_direct_access_enable;
      if (wr_phase && tdr_hit)
        rx_fifo_wdata <= hwdata[`TEST_DATA_W-1:0];
    end
  end

  // Pop is a same-cycle pulse; the FIFO's head is captured with it
  assign tx_fifo_pop = rd_phase && tdr_hit && fifo_direct_access_enable;

  // Pads are asynchronous to hclk
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end
    else
    begin
      pin_s1_q <= {link.ring_indicate_n, link.carrier_detect_n,
                   link.clear_to_send_n, link.set_ready_n,
                   link.infrared_in, link.serial_rx_data};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Clear inputs come from same-clock DMA logic, so no synchroniser
  assign int_tx_dma_clear = integration_mode_enable
                            ? input_hold_q[1] : link.tx_dma_clear;
  assign int_rx_dma_clear = integration_mode_enable
                            ? input_hold_q[0] : link.rx_dma_clear;

  assign out_mux = integration_mode_enable ? ovr_q : func_out;

  assign link.tx_single_dma_request = out_mux[`OVR_TXSREQ];
  assign link.tx_burst_dma_request  = out_mux[`OVR_TXBREQ];
  assign link.rx_single_dma_request = out_mux[`OVR_RXSREQ];
  assign link.rx_burst_dma_request  = out_mux[`OVR_RXBREQ];
  assign link.modem_status_irq      = out_mux[`OVR_MSIRQ];
  assign link.receive_irq           = out_mux[`OVR_RXIRQ];
  assign link.transmit_irq          = out_mux[`OVR_TXIRQ];
  assign link.receive_timeout_irq   = out_mux[`OVR_RTIRQ];
  assign link.error_irq             = out_mux[`OVR_ERRIRQ];
  assign link.combined_irq          = out_mux[`OVR_ALLIRQ];
  assign link.user_output_two_n     = out_mux[`OVR_OUT2];
  assign link.user_output_one_n     = out_mux[`OVR_OUT1];
  assign link.request_to_send_n     = out_mux[`OVR_RTS];
  assign link.terminal_ready_n      = out_mux[`OVR_DTR];
  assign link.infrared_out_n        = out_mux[`OVR_IROUT];
  assign link.serial_tx_data        = out_mux[`OVR_TXD];

  // Read mux; reserved and unmapped bits read as zero
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    case (addr_q)
      `TEST_CTRL_OFS:
        rdata_d = 32'(tcr_q);
      `INPUT_REG_OFS:
        rdata_d = 32'({int_tx_dma_clear, int_rx_dma_clear,
                       pin_s2_q});
      `OUTPUT_OVR_OFS:
        rdata_d = 32'({out_mux[`OUTPUT_OVR_W-1:`OVR_INTRA_LSB],
                       ovr_q[`OVR_PRIM_MSB:0]});
      `TEST_DATA_OFS:
        rdata_d = fifo_direct_access_enable
                  ? 32'(tx_fifo_rdata) : 32'h0000_0000;
      default:
        rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_phase)
      hrdata <= rdata_d;
  end

endmodule

// [verilog/uart_it_link.sv]
// Wires between the harness and the DMA controller, interrupt
// controller and pad loopback fixture. Assumes one shared clock.
`timescale 1ns/1ps

interface uart_it_link;
  logic tx_single_dma_request;
  logic tx_burst_dma_request;
  logic rx_single_dma_request;
  logic rx_burst_dma_request;
  logic modem_status_irq;
  logic receive_irq;
  logic transmit_irq;
  logic receive_timeout_irq;
  logic error_irq;
  logic combined_irq;
  logic user_output_two_n;
  logic user_output_one_n;
  logic request_to_send_n;
  logic terminal_ready_n;
  logic infrared_out_n;
  logic serial_tx_data;
  logic serial_rx_data;
  logic infrared_in;
  logic clear_to_send_n;
  logic carrier_detect_n;
  logic set_ready_n;
  logic ring_indicate_n;
  logic tx_dma_clear;
  logic rx_dma_clear;

  modport harness
  (
    output tx_single_dma_request, tx_burst_dma_request,
    output rx_single_dma_request, rx_burst_dma_request,
    output modem_status_irq, receive_irq, transmit_irq,
    output receive_timeout_irq, error_irq, combined_irq,
    output user_output_two_n, user_output_one_n, request_to_send_n,
    output terminal_ready_n, infrared_out_n, serial_tx_data,
    input  serial_rx_data, infrared_in, clear_to_send_n,
    input  carrier_detect_n, set_ready_n, ring_indicate_n,
    input  tx_dma_clear, rx_dma_clear
  );

  modport partner
  (
    input  tx_single_dma_request, tx_burst_dma_request,
    input  rx_single_dma_request, rx_burst_dma_request,
    input  modem_status_irq, receive_irq, transmit_irq,
    input  receive_timeout_irq, error_irq, combined_irq,
    input  user_output_two_n, user_output_one_n, request_to_send_n,
    input  terminal_ready_n, infrared_out_n, serial_tx_data,
    output serial_rx_data, infrared_in, clear_to_send_n,
    output carrier_detect_n, set_ready_n, ring_indicate_n,
    output tx_dma_clear, rx_dma_clear
  );
endinterface

// [verilog/uart_it_partner.sv]
// DMA/interrupt controller test registers and pad loopback fixture.
// Assumes the harness on the link and hclk shared with it.
`timescale 1ns/1ps
`include "uart_it_defines.svh"

module uart_it_partner
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  uart_it_link.partner               link,
  input  wire logic                  loopback_enable,
  input  wire logic                  tx_clear_drive,
  input  wire logic                  rx_clear_drive,
  output logic [`INTRA_W-1:0]        intra_observed_q,
  output logic [`PIN_IN_W-1:0]       pins_observed_q
);

  logic                  tx_clr_q;
  logic                  rx_clr_q;
  logic [`PIN_IN_W-1:0]  loop_src;
  logic [`PIN_IN_W-1:0]  loop_drv;
  logic [`INTRA_W-1:0]   intra_in;

  // DMA controller test registers toggle the clear lines
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_clr_q <= 1'b0;
      rx_clr_q <= 1'b0;
    end
    else
    begin
      tx_clr_q <= tx_clear_drive;
      rx_clr_q <= rx_clear_drive;
    end
  end

  assign link.tx_dma_clear = tx_clr_q;
  assign link.rx_dma_clear = rx_clr_q;

  // Outputs in the order of the pad inputs that they feed below
  assign loop_src = {link.user_output_two_n, link.user_output_one_n,
                     link.terminal_ready_n, link.request_to_send_n,
                     link.infrared_out_n, link.serial_tx_data};

  // Unjoined pins sit at their inactive high level
  assign loop_drv = loopback_enable ? loop_src : `PIN_IDLE;

  assign link.ring_indicate_n  = loop_drv[5];
  assign link.carrier_detect_n = loop_drv[4];
  assign link.set_ready_n      = loop_drv[3];
  assign link.clear_to_send_n  = loop_drv[2];
  assign link.infrared_in      = loop_drv[1];
  assign link.serial_rx_data   = loop_drv[0];

  assign intra_in = {link.tx_single_dma_request, link.tx_burst_dma_request,
                     link.rx_single_dma_request, link.rx_burst_dma_request,
                     link.modem_status_irq, link.receive_irq,
                     link.transmit_irq, link.receive_timeout_irq,
                     link.error_irq, link.combined_irq};

  // Controller-side test registers that capture what arrives
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      intra_observed_q <= '0;
      pins_observed_q  <= '0;
    end
    else
    begin
      intra_observed_q <= intra_in;
      pins_observed_q  <= loop_src;
    end
  end

endmodule

// [verilog/uart_it_pkg.sv]
// Types used by the harness bus logic; the partner uses none of them.
// Assumes nothing beyond a SystemVerilog compiler.
package uart_it_pkg;

  typedef enum logic [1:0]
  {
    BUS_IDLE    = 2'b00,
    BUS_WRITE   = 2'b01,
    BUS_RD_WAIT = 2'b10,
    BUS_RD_DONE = 2'b11
  } bus_state_e;

endpackage
